// File: sldfs_top.v
// Overview of operation
// - link control bit 3: 0 single, 1 dual
// - link control bit 2 pages unpacker zero/one
// - enable field 01 one link, 11 both
// - soft reset write 0x09 holds paged unpacker
// - soft reset write 0x01 releases paged unpacker
// - 0x453 bit 7 turns descrambling on
// - 0x453 bits 4:0 lanes minus one
// - 0x458 bits 7:5 timing subclass 0 or 1
// - 0x458 bits 4:0 sample bits minus one
// - serial mode bit 5 gives topology
//
// Chosen here: the address-and-strobe port.
`include "sldfs_defs.vh"

module sldfs_top #(
    parameter WORD_W = 32
) (
    input  wire                     clk,
    input  wire                     sys_rst,
    input  wire [`SLDFS_ADDR_W-1:0] reg_addr,
    input  wire [7:0]               reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [7:0]               reg_rdata,
    input  wire                     lane0_valid,
    input  wire [WORD_W-1:0]        lane0_word,
    input  wire                     lane1_valid,
    input  wire [WORD_W-1:0]        lane1_word,
    output wire                     sample0_valid,
    output wire [WORD_W-1:0]        sample0_word,
    output wire                     sample1_valid,
    output wire [WORD_W-1:0]        sample1_word,
    output reg                      topology_dual,
    output reg                      mode_mismatch,
    output reg                      channel_bypass,
    output reg  [1:0]               timing_subclass_field
);

// =====================================================================
// address decode, shared by write and read paths
function hit;
    input [`SLDFS_ADDR_W-1:0] a;
    input [`SLDFS_ADDR_W-1:0] ofs;
    begin
        hit = (a == ofs);
    end
endfunction

// =====================================================================
// register storage
reg  [`SLDFS_LC_W-1:0]   link_control;
reg  [`SLDFS_MODE_W-1:0] serial_mode_code;
reg  [`SLDFS_UPS_W-1:0]  channel_upsample_ratio;
reg  [7:0]               wht_lanes0;
reg  [7:0]               wht_lanes1;
reg  [7:0]               sub_width0;
reg  [7:0]               sub_width1;
reg  [7:0]               srst0;
reg  [7:0]               srst1;
reg  [7:0]               next_rdata;

wire page;
wire wr_unp0;
wire wr_unp1;
wire err_now;

assign page    = link_control[`SLDFS_LC_PAGE_BIT];
assign wr_unp0 = reg_wr & ~page;
assign wr_unp1 = reg_wr &  page;
// topology bit must agree with the mode code; software sees a flag
assign err_now = link_control[`SLDFS_LC_TOPOLOGY_BIT]
               ^ serial_mode_code[`SLDFS_MODE_TOPO_BIT];

// =====================================================================
// write path
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        link_control           <= `SLDFS_LC_RESET;
        serial_mode_code       <= `SLDFS_MODE_RESET;
        channel_upsample_ratio <= `SLDFS_UPS_RESET;
        wht_lanes0             <= `SLDFS_WHT_LANES_RESET;
        wht_lanes1             <= `SLDFS_WHT_LANES_RESET;
        sub_width0             <= `SLDFS_SUB_WIDTH_RESET;
        sub_width1             <= `SLDFS_SUB_WIDTH_RESET;
        srst0                  <= `SLDFS_SRST_RESET;
        srst1                  <= `SLDFS_SRST_RESET;
    end else begin
        if (reg_wr && hit(reg_addr, `SLDFS_OFS_LINK_CONTROL)) begin
            link_control <= reg_wdata[`SLDFS_LC_W-1:0];
        end
        if (reg_wr && hit(reg_addr, `SLDFS_OFS_SERIAL_MODE)) begin
            serial_mode_code <= reg_wdata[`SLDFS_MODE_W-1:0];
        end
        if (reg_wr && hit(reg_addr, `SLDFS_OFS_UPSAMPLE)) begin
            channel_upsample_ratio <= reg_wdata[`SLDFS_UPS_W-1:0];
        end
        if (wr_unp0 && hit(reg_addr, `SLDFS_OFS_WHT_LANES)) begin
            wht_lanes0 <= reg_wdata;
        end
        if (wr_unp1 && hit(reg_addr, `SLDFS_OFS_WHT_LANES)) begin
            wht_lanes1 <= reg_wdata;
        end
        if (wr_unp0 && hit(reg_addr, `SLDFS_OFS_SUB_WIDTH)) begin
            sub_width0 <= reg_wdata;
        end
        if (wr_unp1 && hit(reg_addr, `SLDFS_OFS_SUB_WIDTH)) begin
            sub_width1 <= reg_wdata;
        end
        if (wr_unp0 && hit(reg_addr, `SLDFS_OFS_SOFT_RESET)) begin
            srst0 <= reg_wdata;
        end
        if (wr_unp1 && hit(reg_addr, `SLDFS_OFS_SOFT_RESET)) begin
            srst1 <= reg_wdata;
        end
    end
end

// =====================================================================
// read path: data stand in the cycle after the strobe only
always @* begin
    next_rdata = 8'h00;
    if (hit(reg_addr, `SLDFS_OFS_LINK_CONTROL)) begin
        next_rdata = {4'h0, link_control};
    end else if (hit(reg_addr, `SLDFS_OFS_SERIAL_MODE)) begin
        next_rdata = {err_now, 1'b0, serial_mode_code};
    end else if (hit(reg_addr, `SLDFS_OFS_UPSAMPLE)) begin
        next_rdata = {4'h0, channel_upsample_ratio};
    end else if (hit(reg_addr, `SLDFS_OFS_WHT_LANES)) begin
        next_rdata = page ? wht_lanes1 : wht_lanes0;
    end else if (hit(reg_addr, `SLDFS_OFS_SUB_WIDTH)) begin
        next_rdata = page ? sub_width1 : sub_width0;
    end else if (hit(reg_addr, `SLDFS_OFS_SOFT_RESET)) begin
        next_rdata = page ? srst1 : srst0;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= 8'h00;
    end
end

// =====================================================================
// status outputs, registered
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        topology_dual         <= 1'b0;
        mode_mismatch         <= 1'b0;
        channel_bypass        <= 1'b1;
        timing_subclass_field <= 2'b00;
    end else begin
        topology_dual  <= link_control[`SLDFS_LC_TOPOLOGY_BIT];
        mode_mismatch  <= err_now;
        // 1x upsampling means the channel stage is bypassed
        channel_bypass <= (channel_upsample_ratio == `SLDFS_UPS_BYPASS);
        timing_subclass_field <= {
            sub_width1[`SLDFS_SUBCLASS_LO],
            sub_width0[`SLDFS_SUBCLASS_LO]};
    end
end

// =====================================================================
// the two quad-byte unpackers
sldfs_unpacker #(
    .WORD_W (WORD_W)
) u_first_unpacker (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .enable                (link_control[`SLDFS_LC_EN_LO]),
    .soft_rst              (srst0[`SLDFS_SRST_HOLD_BIT]),
    .payload_whitening_on  (wht_lanes0[`SLDFS_WHT_BIT]),
    .lanes_minus_one       (wht_lanes0[`SLDFS_LANES_HI:0]),
    .sample_bits_minus_one (sub_width0[`SLDFS_SBITS_HI:0]),
    .lane_valid            (lane0_valid),
    .lane_word             (lane0_word),
    .sample_valid          (sample0_valid),
    .sample_word           (sample0_word)
);

// the second unpacker only runs once both enable bits are set
sldfs_unpacker #(
    .WORD_W (WORD_W)
) u_second_unpacker (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .enable                (link_control[`SLDFS_LC_EN_HI]
                            & link_control[`SLDFS_LC_EN_LO]),
    .soft_rst              (srst1[`SLDFS_SRST_HOLD_BIT]),
    .payload_whitening_on  (wht_lanes1[`SLDFS_WHT_BIT]),
    .lanes_minus_one       (wht_lanes1[`SLDFS_LANES_HI:0]),
    .sample_bits_minus_one (sub_width1[`SLDFS_SBITS_HI:0]),
    .lane_valid            (lane1_valid),
    .lane_word             (lane1_word),
    .sample_valid          (sample1_valid),
    .sample_word           (sample1_word)
);

endmodule

// File: sldfs_defs.vh
`ifndef SLDFS_DEFS_VH
`define SLDFS_DEFS_VH

// =====================================================================
// register offsets
`define SLDFS_ADDR_W            12
`define SLDFS_OFS_SERIAL_MODE   12'h110
`define SLDFS_OFS_UPSAMPLE      12'h111
`define SLDFS_OFS_LINK_CONTROL  12'h300
`define SLDFS_OFS_WHT_LANES     12'h453
`define SLDFS_OFS_SUB_WIDTH     12'h458
`define SLDFS_OFS_SOFT_RESET    12'h475

// =====================================================================
// link control fields
`define SLDFS_LC_TOPOLOGY_BIT   3
`define SLDFS_LC_PAGE_BIT       2
`define SLDFS_LC_EN_HI          1
`define SLDFS_LC_EN_LO          0
`define SLDFS_LC_W              4
`define SLDFS_LC_RESET          4'h0

// =====================================================================
// serial mode code and upsample ratio fields
`define SLDFS_MODE_TOPO_BIT     5
`define SLDFS_MODE_W            6
`define SLDFS_MODE_ERR_BIT      7
`define SLDFS_MODE_RESET        6'h00
`define SLDFS_UPS_W             4
`define SLDFS_UPS_RESET         4'h1
`define SLDFS_UPS_BYPASS        4'h1

// =====================================================================
// per-unpacker fields
`define SLDFS_WHT_BIT           7
`define SLDFS_LANES_HI          4
`define SLDFS_SUBCLASS_HI       7
`define SLDFS_SUBCLASS_LO       5
`define SLDFS_SBITS_HI          4
`define SLDFS_SRST_HOLD_BIT     3
`define SLDFS_SRST_ENTER        8'h09
`define SLDFS_SRST_LEAVE        8'h01
`define SLDFS_WHT_LANES_RESET   8'h00
`define SLDFS_SUB_WIDTH_RESET   8'h0F
`define SLDFS_SRST_RESET        8'h01

`endif

// File: sldfs_unpacker.v
`include "sldfs_defs.vh"

module sldfs_unpacker #(
    parameter WORD_W  = 32,
    parameter WHT_W   = 15
) (
    input  wire              clk,
    input  wire              sys_rst,
    input  wire              enable,
    input  wire              soft_rst,
    input  wire              payload_whitening_on,
    input  wire [4:0]        lanes_minus_one,
    input  wire [4:0]        sample_bits_minus_one,
    input  wire              lane_valid,
    input  wire [WORD_W-1:0] lane_word,
    output reg               sample_valid,
    output reg  [WORD_W-1:0] sample_word
);

// =====================================================================
// self-synchronous descrambler, 1 + x^14 + x^15, msb first
function [WHT_W+WORD_W-1:0] descramble;
    input [WORD_W-1:0] w;
    input [WHT_W-1:0]  s;
    integer            i;
    reg   [WHT_W-1:0]  st;
    reg   [WORD_W-1:0] o;
    begin
        st = s;
        o  = {WORD_W{1'b0}};
        for (i = WORD_W-1; i >= 0; i = i - 1) begin
            o[i] = w[i] ^ st[WHT_W-2] ^ st[WHT_W-1];
            st   = {st[WHT_W-2:0], w[i]};
        end
        descramble = {st, o};
    end
endfunction

reg  [WHT_W-1:0]        wht_state;
reg  [WHT_W+WORD_W-1:0] dres;
reg  [WORD_W-1:0]       payload;
reg  [WORD_W-1:0]       next_word;
wire [WORD_W-1:0]       width_mask;
wire                    run;
integer                 k;

// =====================================================================
// gating and shaping
assign run = enable & ~soft_rst;
assign width_mask = {WORD_W{1'b1}} >> (5'd31 - sample_bits_minus_one);

always @* begin
    dres    = descramble(lane_word, wht_state);
    payload = payload_whitening_on ? dres[WORD_W-1:0] : lane_word;
    // lanes beyond the programmed count carry no payload
    for (k = 0; k < WORD_W/8; k = k + 1) begin
        if (k > lanes_minus_one) begin
            payload[k*8 +: 8] = 8'h00;
        end
    end
    next_word = payload & width_mask;
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        wht_state    <= {WHT_W{1'b0}};
        sample_valid <= 1'b0;
        sample_word  <= {WORD_W{1'b0}};
    end else if (!run) begin
        // a held unpacker forgets its descrambler history
        wht_state    <= {WHT_W{1'b0}};
        sample_valid <= 1'b0;
    end else begin
        sample_valid <= lane_valid;
        if (lane_valid) begin
            wht_state   <= dres[WHT_W+WORD_W-1:WORD_W];
            sample_word <= next_word;
        end
    end
end

endmodule

// File: sldfs_top_monitor.sv
// ==================================================
// checker: shadows the software view of the registers
module sldfs_top_monitor #(parameter WORD_W = 32) (
    input wire              clk,
    input wire              sys_rst,
    input wire [11:0]       reg_addr,
    input wire [7:0]        reg_wdata,
    input wire              reg_wr,
    input wire              reg_rd,
    input wire [7:0]        reg_rdata,
    input wire              lane0_valid,
    input wire [WORD_W-1:0] lane0_word,
    input wire              lane1_valid,
    input wire [WORD_W-1:0] lane1_word,
    input wire              sample0_valid,
    input wire [WORD_W-1:0] sample0_word,
    input wire              sample1_valid,
    input wire [WORD_W-1:0] sample1_word,
    input wire              topology_dual,
    input wire              mode_mismatch,
    input wire              channel_bypass,
    input wire [1:0]        timing_subclass_field
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [3:0] lc;
    reg       mode5;
    reg [1:0] hold;
    reg [1:0] sub;
    reg [1:0] quiet;
    wire      run0 = lc[0] & ~hold[0];
    wire      run1 = lc[1] & lc[0] & ~hold[1];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // quiet: edges since the last write, so output flops may lag by two
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {lc, mode5, hold, sub, quiet} <= 11'h000;
        end else begin
            quiet <= reg_wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
            if (reg_wr) begin
                case (reg_addr)
                    12'h300: lc <= reg_wdata[3:0];
                    12'h110: mode5 <= reg_wdata[5];
                    12'h475: hold[lc[2]] <= reg_wdata[3];
                    12'h458: sub[lc[2]] <= reg_wdata[5];
                    default: ;
                endcase
            end
        end
    end
    chk_run0_emits: assert property (
        quiet[1] && run0 && lane0_valid |=> sample0_valid)
        else $error("unpacker 0 dropped a word");
    chk_stop0_silent: assert property (
        quiet[1] && !(run0 && lane0_valid) |=> !sample0_valid)
        else $error("unpacker 0 emitted while stopped");
    chk_run1_emits: assert property (
        quiet[1] && run1 && lane1_valid |=> sample1_valid)
        else $error("unpacker 1 dropped a word");
    chk_stop1_silent: assert property (
        quiet[1] && !(run1 && lane1_valid) |=> !sample1_valid)
        else $error("unpacker 1 emitted while stopped");
    chk_topo_copy: assert property (
        quiet[1] |-> topology_dual == lc[3])
        else $error("topology output disagrees");
    chk_mode_check: assert property (
        quiet[1] |-> mode_mismatch == (lc[3] != mode5))
        else $error("mode mismatch flag wrong");
    chk_subclass_out: assert property (
        quiet[1] |-> timing_subclass_field == sub)
        else $error("subclass output wrong");
    chk_read_link: assert property (
        reg_rd && reg_addr == 12'h300 |=> reg_rdata == {4'h0, $past(lc)})
        else $error("link control readback wrong");
    cover property (run0 && lane0_valid);
    cover property (run1 && lane1_valid);
    cover property (mode_mismatch);
endmodule

bind sldfs_top sldfs_top_monitor #(.WORD_W(WORD_W)) u_mon (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lane0_valid(lane0_valid),
    .lane0_word(lane0_word), .lane1_valid(lane1_valid),
    .lane1_word(lane1_word), .sample0_valid(sample0_valid),
    .sample0_word(sample0_word), .sample1_valid(sample1_valid),
    .sample1_word(sample1_word), .topology_dual(topology_dual),
    .mode_mismatch(mode_mismatch), .channel_bypass(channel_bypass),
    .timing_subclass_field(timing_subclass_field));

// File: sldfs_top_test.sv
module sldfs_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [11:0] reg_addr = 12'h000;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [1:0]  lv = 2'b00;
    reg  [31:0] lw [0:1];
    wire [7:0]  reg_rdata;
    wire [1:0]  sv;
    wire [31:0] sw [0:1];
    wire        topo;
    wire        mism;
    wire        byp;
    wire [1:0]  subc;
    integer     failures = 0;
    integer     checks = 0;
    integer     seed = 32'h3443;
    integer     k;
    reg         traffic = 1'b0;
    // ==================================================
    // behavioural model of the registers and unpackers
    reg  [3:0]  m_lc = 4'h0;
    reg  [5:0]  m_mode = 6'h00;
    reg  [3:0]  m_ups = 4'h1;
    reg  [7:0]  m_wht [0:1] = '{8'h00, 8'h00};
    reg  [7:0]  m_sub [0:1] = '{8'h0F, 8'h0F};
    reg  [7:0]  m_srst [0:1] = '{8'h01, 8'h01};
    reg  [14:0] m_st [0:1] = '{15'h0, 15'h0};
    reg  [1:0]  exp_v = 2'b00;
    reg  [31:0] exp_w [0:1];
    initial forever #50 clk = ~clk;
    sldfs_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .lane0_valid(lv[0]), .lane0_word(lw[0]),
        .lane1_valid(lv[1]), .lane1_word(lw[1]), .sample0_valid(sv[0]),
        .sample0_word(sw[0]), .sample1_valid(sv[1]), .sample1_word(sw[1]),
        .topology_dual(topo), .mode_mismatch(mism),
        .channel_bypass(byp), .timing_subclass_field(subc));
    task chk_data(input [95:0] nm, input [31:0] e, input [31:0] g);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
        end
    endtask
    task chk_flag(input [95:0] nm, input e, input g);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %0s exp %b got %b", nm, e, g);
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        case (a)
            12'h300: m_lc <= d[3:0];
            12'h110: m_mode <= d[5:0];
            12'h111: m_ups <= d[3:0];
            12'h453: m_wht[m_lc[2]] <= d;
            12'h458: m_sub[m_lc[2]] <= d;
            12'h475: m_srst[m_lc[2]] <= d;
            default: ;
        endcase
    endtask
    function [7:0] mread(input [11:0] a);
        case (a)
            12'h300: mread = {4'h0, m_lc};
            12'h110: mread = {m_lc[3] != m_mode[5], 1'b0, m_mode};
            12'h111: mread = {4'h0, m_ups};
            12'h453: mread = m_wht[m_lc[2]];
            12'h458: mread = m_sub[m_lc[2]];
            12'h475: mread = m_srst[m_lc[2]];
            default: mread = 8'h00;
        endcase
    endfunction
    // one pass over every mapped place plus an unmapped one
    task rd_all;
        reg [11:0] a;
        for (k = 0; k < 7; k = k + 1) begin
            a = k == 6 ? 12'h200 : 12'({12'h110, 12'h111, 12'h300, 12'h453,
                12'h458, 12'h475} >> (12 * (5 - k)));
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk_data("reg read", {24'h0, mread(a)}, {24'h0, reg_rdata});
        end
    endtask
    task status;
        repeat (3) @(posedge clk);
        #1 chk_flag("topology", m_lc[3], topo);
        chk_flag("mismatch", m_lc[3] != m_mode[5], mism);
        chk_flag("bypass", m_ups == 4'h1, byp);
        chk_data("subclass", {m_sub[1][5], m_sub[0][5]}, {30'h0, subc});
    endtask
    always @(posedge clk) begin
        lv <= {2{traffic}} & 2'($random(seed));
        lw[0] <= $random(seed);
        lw[1] <= $random(seed);
    end
    always @(posedge clk) begin : lanes
        integer u, i;
        reg [31:0] w;
        reg run, b;
        for (u = 0; u < 2 && !sys_rst; u = u + 1) begin
            if (exp_v[u]) chk_data("sample word", exp_w[u], sw[u]);
            chk_flag("sample valid", exp_v[u], sv[u]);
            run = m_lc[0] & ~m_srst[u][3] & (u == 0 | m_lc[1]);
            exp_v[u] = run & lv[u];
            w = lw[u];
            if (!run) m_st[u] = 15'h0;
            if (exp_v[u]) begin
                // descrambler sees the raw lane word, cuts come after it
                for (i = 31; i >= 0 && m_wht[u][7]; i = i - 1) begin
                    b = w[i];
                    w[i] = b ^ m_st[u][13] ^ m_st[u][14];
                    m_st[u] = {m_st[u][13:0], b};
                end
                for (i = 0; i < 4; i = i + 1)
                    if (i > m_wht[u][4:0]) w[8*i +: 8] = 8'h00;
                w = w & (32'hFFFFFFFF >> (31 - m_sub[u][4:0]));
                exp_w[u] = w;
            end
        end
    end
    task complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #2000000 failures = failures + 1;
        complete_run;
    end
    // ==================================================
    // scenarios: reset values, disabled links, both setups, modes
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd_all;
        status;
        traffic <= 1'b1;
        wr(12'h110, 8'h25);
        // second unpacker first, links kept off while it is paged
        wr(12'h300, 8'h0C);
        wr(12'h475, 8'h09);
        wr(12'h453, 8'h83);
        wr(12'h458, 8'h3F);
        wr(12'h475, 8'h01);
        rd_all;
        for (int c = 0; c < 3; c = c + 1) begin
            wr(12'h300, 8'h08);
            wr(12'h475, 8'h09);
            wr(12'h453, c == 0 ? 8'h03 : c == 1 ? 8'h01 : 8'hE0);
            wr(12'h458, c == 0 ? 8'h2F : c == 1 ? 8'h0B : 8'h1F);
            wr(12'h300, 8'h0B);
            repeat (10) @(posedge clk);
            rd_all;
            wr(12'h475, 8'h01);
            repeat (40) @(posedge clk);
            status;
            wr(12'h300, 8'h01);
            repeat (20) @(posedge clk);
            status;
        end
        wr(12'h111, 8'h02);
        status;
        wr(12'h111, 8'h01);
        rd_all;
        complete_run;
    end
endmodule
